// file: design/pvmr_pkg.sv
// Operation
// - Partner ability word is read-only; bit 15 next page, bit 14 word received.
// - Partner remote-fault bit 13 set forces basic status remote-fault bit to one.
// - Partner abilities on bits 9..5 and selector on bits 4..0.
// - Spec control bit 5 enables automatic crossover even with autonegotiation off.
// - In fiber mode far-end fault runs when bit 4 is zero, off when one.
// - Spec control bit 3 selects repeater mode, zero selects normal mode.
// - Spec control bit 2 enables jabber detection only at 10BASE-T.
// - Spec control bit 1 enables heartbeat detection only at 10BASE-T.
// - Spec control bit 0 bypasses the signal-processor reset watchdog.
// - Debug register at index 0x17; bit 5 accelerates autonegotiation timers.
// - Debug bit 4 shortens signal-processor training sequences.
// - Debug bit 3 forces link up regardless of line condition.
// - Debug bit 2 bypasses scrambler and descrambler.
// - Debug two-bit select chooses which autonegotiation probes reach status output.
// - Status bit 15 sleep, bit 14 link good, bit 13 descrambler lock.
// - Status bit 12 shows reversed polarity, meaningful only at 10BASE-T.
// - Status bit 11 speed (1 = 100), bit 10 duplex (1 = full).
// - Status bit 9 shows crossover (one) or straight (zero).
// - Analyzer register at 0x22; bit 15 enables, bit 14 selects crossover pair.
// - Analyzer bit 10 set sends one test pulse per analyzer write.
// - Analyzer phase step per write: 00 hold, 01 up, 11 down, 10 reserved.
// - Capture length above zero needed for a capture after a pulse.
package pvmr_pkg;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [4:0] PVMR_IDX_BASIC_STATUS = 5'h01;
  localparam logic [4:0] PVMR_IDX_PARTNER = 5'h05;
  localparam logic [4:0] PVMR_IDX_SPEC_CTRL = 5'h10;
  localparam logic [4:0] PVMR_IDX_DEBUG = 5'h17;
  localparam logic [4:0] PVMR_IDX_STATUS_MON = 5'h18;
  localparam logic [5:0] PVMR_IDX_ANALYZER = 6'h22;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [15:0] PVMR_SPEC_RST = 16'h0000;
  localparam logic [15:0] PVMR_DEBUG_RST = 16'h0000;
  localparam logic [15:0] PVMR_ANALYZER_RST = 16'h0000;
  localparam logic [15:0] PVMR_SPEC_MASK = 16'h003F;
  localparam logic [15:0] PVMR_DEBUG_MASK = 16'h003F;
  localparam logic [15:0] PVMR_ANALYZER_MASK = 16'hC7FF;
  localparam logic [15:0] PVMR_PARTNER_MASK = 16'hE3FF;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PVMR_BS_REMOTE_FAULT = 4;
  localparam int PVMR_LP_REMOTE_FAULT = 13;
  localparam int PVMR_SC_AUTOX = 5;
  localparam int PVMR_SC_FEF_OFF = 4;
  localparam int PVMR_SC_REPEAT = 3;
  localparam int PVMR_SC_JABBER = 2;
  localparam int PVMR_SC_HEARTBEAT = 1;
  localparam int PVMR_SC_SKIP_WDOG = 0;
  localparam int PVMR_DB_AN_FAST = 5;
  localparam int PVMR_DB_DSP_FAST = 4;
  localparam int PVMR_DB_FORCE_LINK = 3;
  localparam int PVMR_DB_SCRAM_SKIP = 2;
  localparam int PVMR_AZ_ENABLE = 15;
  localparam int PVMR_AZ_PAIR = 14;
  localparam int PVMR_AZ_PULSE = 10;

  // ----------------------------------------
  // Phase step codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PVMR_PH_HOLD = 2'b00,
    PVMR_PH_INC = 2'b01,
    PVMR_PH_RSVD = 2'b10,
    PVMR_PH_DEC = 2'b11
  } pvmr_phase_t;

  localparam logic [7:0] PVMR_PHASE_RST = 8'h00;

endpackage : pvmr_pkg

// file: design/pvmr_top.sv
`timescale 1ns/1ps
`default_nettype none
module pvmr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Management access port
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [5:0] mgmt_idx,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // Line status from the physical layer core
  input wire logic [15:0] partner_word,
  input wire logic [15:0] basic_status_core,
  input wire logic link_down_sleep_flag,
  input wire logic line_link_good,
  input wire logic descrambler_locked_flag,
  input wire logic reversed_pair_polarity,
  input wire logic negotiated_rate,
  input wire logic negotiated_duplex,
  input wire logic crossover_state,
  input wire logic fiber_mode,
  input wire logic [35:0] autoneg_probes,
  // Controls to the physical layer core
  output logic auto_crossover_enable,
  output logic far_end_fault_active,
  output logic repeater_mode,
  output logic jabber_check_active,
  output logic heartbeat_check_active,
  output logic skip_dsp_reset_watchdog,
  output logic autoneg_timer_accelerate,
  output logic dsp_training_shorten,
  output logic link_up_forced,
  output logic scrambler_skip,
  output logic analyzer_enable,
  output logic analyzer_pair_select,
  output logic analyzer_pulse,
  output logic [7:0] analyzer_phase,
  output logic [7:0] analyzer_sample_window,
  output logic analyzer_capture_armed
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [15:0] spec_reg, spec_next;
  logic [15:0] debug_reg, debug_next;
  logic [15:0] analyzer_reg, analyzer_next;
  logic [7:0] phase_reg, phase_next;
  logic pulse_reg, pulse_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [35:0] probe_s1_reg, probe_s2_reg;
  logic [8:0] stat_s1_reg, stat_s2_reg;
  logic link_good;
  logic ten_base;
  logic [8:0] probe_out;
  logic [15:0] status_mon;
  logic [15:0] partner_view;
  logic [15:0] basic_view;
  logic az_wr;
  pvmr_pkg::pvmr_phase_t step;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      probe_s1_reg <= 36'h0;
      probe_s2_reg <= 36'h0;
      stat_s1_reg <= 9'h000;
      stat_s2_reg <= 9'h000;
    end else begin
      probe_s1_reg <= autoneg_probes;
      probe_s2_reg <= probe_s1_reg;
      stat_s1_reg <= {link_down_sleep_flag, line_link_good, descrambler_locked_flag, reversed_pair_polarity,
                      negotiated_rate, negotiated_duplex, crossover_state, fiber_mode, 1'b0};
      stat_s2_reg <= stat_s1_reg;
    end
  end

  // ----------------------------------------
  // Status views
  // ----------------------------------------
  always_comb begin
    link_good = stat_s2_reg[7] | debug_reg[pvmr_pkg::PVMR_DB_FORCE_LINK];
    ten_base = ~stat_s2_reg[4];
    case (debug_reg[1:0])
      2'b00: probe_out = probe_s2_reg[8:0];
      2'b01: probe_out = probe_s2_reg[17:9];
      2'b10: probe_out = probe_s2_reg[26:18];
      2'b11: probe_out = probe_s2_reg[35:27];
      default: probe_out = 9'h000;
    endcase
    status_mon = {stat_s2_reg[8], link_good, stat_s2_reg[6],
                  stat_s2_reg[5] & ten_base,
                  stat_s2_reg[4], stat_s2_reg[3],
                  stat_s2_reg[2], probe_out};
    partner_view = partner_word & pvmr_pkg::PVMR_PARTNER_MASK;
    basic_view = basic_status_core;
    basic_view[pvmr_pkg::PVMR_BS_REMOTE_FAULT] = basic_status_core[pvmr_pkg::PVMR_BS_REMOTE_FAULT] |
                                                 partner_word[pvmr_pkg::PVMR_LP_REMOTE_FAULT];
  end

  // ----------------------------------------
  // Register write and read
  // ----------------------------------------
  always_comb begin
    spec_next = spec_reg;
    debug_next = debug_reg;
    analyzer_next = analyzer_reg;
    phase_next = phase_reg;
    pulse_next = 1'b0;
    rvalid_next = mgmt_rd;
    rdata_next = 16'h0000;
    az_wr = mgmt_wr && (mgmt_idx == pvmr_pkg::PVMR_IDX_ANALYZER);
    step = pvmr_pkg::pvmr_phase_t'(mgmt_wdata[9:8]);
    if (mgmt_wr) begin
      if (mgmt_idx == {1'b0, pvmr_pkg::PVMR_IDX_SPEC_CTRL}) begin
        spec_next = mgmt_wdata & pvmr_pkg::PVMR_SPEC_MASK;
      end
      if (mgmt_idx == {1'b0, pvmr_pkg::PVMR_IDX_DEBUG}) begin
        debug_next = mgmt_wdata & pvmr_pkg::PVMR_DEBUG_MASK;
      end
    end
    if (az_wr) begin
      analyzer_next = mgmt_wdata & pvmr_pkg::PVMR_ANALYZER_MASK;
      pulse_next = mgmt_wdata[pvmr_pkg::PVMR_AZ_PULSE];
      case (step)
        pvmr_pkg::PVMR_PH_HOLD: phase_next = phase_reg;
        pvmr_pkg::PVMR_PH_INC: phase_next = phase_reg + 8'h01;
        pvmr_pkg::PVMR_PH_DEC: phase_next = phase_reg - 8'h01;
        default: phase_next = phase_reg;
      endcase
    end
    if (mgmt_rd) begin
      case (mgmt_idx)
        {1'b0, pvmr_pkg::PVMR_IDX_BASIC_STATUS}: rdata_next = basic_view;
        {1'b0, pvmr_pkg::PVMR_IDX_PARTNER}: rdata_next = partner_view;
        {1'b0, pvmr_pkg::PVMR_IDX_SPEC_CTRL}: rdata_next = spec_reg;
        {1'b0, pvmr_pkg::PVMR_IDX_DEBUG}: rdata_next = debug_reg;
        {1'b0, pvmr_pkg::PVMR_IDX_STATUS_MON}: rdata_next = status_mon;
        pvmr_pkg::PVMR_IDX_ANALYZER: rdata_next = analyzer_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      spec_reg <= pvmr_pkg::PVMR_SPEC_RST;
      debug_reg <= pvmr_pkg::PVMR_DEBUG_RST;
      analyzer_reg <= pvmr_pkg::PVMR_ANALYZER_RST;
      phase_reg <= pvmr_pkg::PVMR_PHASE_RST;
      pulse_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      spec_reg <= spec_next;
      debug_reg <= debug_next;
      analyzer_reg <= analyzer_next;
      phase_reg <= phase_next;
      pulse_reg <= pulse_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  assign mgmt_rdata = rdata_reg;
  assign mgmt_rvalid = rvalid_reg;
  assign auto_crossover_enable = spec_reg[pvmr_pkg::PVMR_SC_AUTOX];
  assign far_end_fault_active = stat_s2_reg[1] & ~spec_reg[pvmr_pkg::PVMR_SC_FEF_OFF];
  assign repeater_mode = spec_reg[pvmr_pkg::PVMR_SC_REPEAT];
  assign jabber_check_active = spec_reg[pvmr_pkg::PVMR_SC_JABBER] & ten_base;
  assign heartbeat_check_active = spec_reg[pvmr_pkg::PVMR_SC_HEARTBEAT] & ten_base;
  assign skip_dsp_reset_watchdog = spec_reg[pvmr_pkg::PVMR_SC_SKIP_WDOG];
  assign autoneg_timer_accelerate = debug_reg[pvmr_pkg::PVMR_DB_AN_FAST];
  assign dsp_training_shorten = debug_reg[pvmr_pkg::PVMR_DB_DSP_FAST];
  assign link_up_forced = debug_reg[pvmr_pkg::PVMR_DB_FORCE_LINK];
  assign scrambler_skip = debug_reg[pvmr_pkg::PVMR_DB_SCRAM_SKIP];
  assign analyzer_enable = analyzer_reg[pvmr_pkg::PVMR_AZ_ENABLE];
  assign analyzer_pair_select = analyzer_reg[pvmr_pkg::PVMR_AZ_PAIR];
  assign analyzer_pulse = pulse_reg;
  assign analyzer_phase = phase_reg;
  assign analyzer_sample_window = analyzer_reg[7:0];
  assign analyzer_capture_armed = analyzer_reg[pvmr_pkg::PVMR_AZ_ENABLE] & (analyzer_reg[7:0] != 8'h00);

endmodule : pvmr_top
`default_nettype wire

// file: verification/pvmr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pvmr_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Management access
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [5:0] mgmt_idx,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_rvalid,
  // Analyzer controls
  input wire logic analyzer_enable,
  input wire logic analyzer_pair_select,
  input wire logic analyzer_pulse,
  input wire logic [7:0] analyzer_phase,
  input wire logic [7:0] analyzer_sample_window,
  input wire logic analyzer_capture_armed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence az_wr_s; mgmt_wr && mgmt_idx == 6'h22; endsequence
  read_answer_a: assert property (mgmt_rd |=> mgmt_rvalid)
    else $error("read not answered next cycle");
  pulse_on_wr_a: assert property (az_wr_s ##0 mgmt_wdata[10] |=> analyzer_pulse)
    else $error("no pulse after analyzer write");
  stray_pulse_a: assert property (analyzer_pulse |->
    $past(mgmt_wr && mgmt_idx == 6'h22 && mgmt_wdata[10]))
    else $error("pulse without analyzer write");
  phase_up_a: assert property (az_wr_s ##0 mgmt_wdata[9:8] == 2'b01 |=>
    analyzer_phase == $past(analyzer_phase) + 8'h01)
    else $error("phase not incremented");
  phase_down_a: assert property (az_wr_s ##0 mgmt_wdata[9:8] == 2'b11 |=>
    analyzer_phase == $past(analyzer_phase) - 8'h01)
    else $error("phase not decremented");
  phase_hold_a: assert property (!(mgmt_wr && mgmt_idx == 6'h22 && mgmt_wdata[8]) |=> $stable(analyzer_phase))
    else $error("phase moved");
  pair_select_a: assert property (az_wr_s |=>
    analyzer_enable == $past(mgmt_wdata[15]) && analyzer_pair_select == $past(mgmt_wdata[14]))
    else $error("analyzer mode or pair wrong");
  capture_arm_a: assert property (analyzer_capture_armed == (analyzer_enable && analyzer_sample_window != 8'h00))
    else $error("capture arming wrong");
endmodule : pvmr_checker
bind pvmr_top pvmr_checker pvmr_checker_i (.clk(clk), .rst_b(rst_b), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
  .mgmt_idx(mgmt_idx), .mgmt_wdata(mgmt_wdata), .mgmt_rvalid(mgmt_rvalid), .analyzer_enable(analyzer_enable),
  .analyzer_pair_select(analyzer_pair_select), .analyzer_pulse(analyzer_pulse), .analyzer_phase(analyzer_phase),
  .analyzer_sample_window(analyzer_sample_window), .analyzer_capture_armed(analyzer_capture_armed));
`default_nettype wire

// file: verification/pvmr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pvmr_host_model (
  // Clock
  input wire logic clk,
  // Management access
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [5:0] mgmt_idx,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  initial begin
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_idx = 6'h00;
    mgmt_wdata = 16'h0000;
  end
  // One-cycle write strobe by register index
  task automatic wr(input logic [5:0] idx, input logic [15:0] data);
    @(posedge clk);
    mgmt_wr <= 1'b1;
    mgmt_idx <= idx;
    mgmt_wdata <= data;
    @(posedge clk);
    mgmt_wr <= 1'b0;
    mgmt_wdata <= ~data;
  endtask : wr
  // One-cycle read strobe, bounded wait for the answer
  task automatic rd(input logic [5:0] idx, output logic [15:0] data, output logic ok);
    @(posedge clk);
    mgmt_rd <= 1'b1;
    mgmt_idx <= idx;
    @(posedge clk);
    mgmt_rd <= 1'b0;
    mgmt_idx <= ~idx;
    ok = 1'b0;
    data = 16'h0000;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge clk);
      ok = (mgmt_rvalid === 1'b1);
      data = mgmt_rdata;
    end
  endtask : rd
endmodule : pvmr_host_model
`default_nettype wire

// file: verification/pvmr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pvmr_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] line_in = 8'hB7;
  logic [35:0] probes = {9'h1A5, 9'h0C3, 9'h05A, 9'h111};
  logic [15:0] partner = 16'hFFFF;
  wire mgmt_wr, mgmt_rd, mgmt_rvalid;
  wire [5:0] mgmt_idx, ctl;
  wire [15:0] mgmt_wdata, mgmt_rdata;
  logic [15:0] w;
  wire [3:0] dbg, az;
  wire [7:0] phase, win;
  logic [7:0] ph;
  int error_cnt = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  pvmr_host_model pvmr_host_model_i (.clk(clk), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_idx(mgmt_idx),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));
  pvmr_top pvmr_top_i (.clk(clk), .rst_b(rst_b), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_idx(mgmt_idx),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .partner_word(partner),
    .basic_status_core(16'h0000), .link_down_sleep_flag(line_in[7]), .line_link_good(line_in[6]),
    .descrambler_locked_flag(line_in[5]), .reversed_pair_polarity(line_in[4]), .negotiated_rate(line_in[3]),
    .negotiated_duplex(line_in[2]), .crossover_state(line_in[1]), .fiber_mode(line_in[0]), .autoneg_probes(probes),
    .auto_crossover_enable(ctl[5]), .far_end_fault_active(ctl[4]), .repeater_mode(ctl[3]),
    .jabber_check_active(ctl[2]), .heartbeat_check_active(ctl[1]), .skip_dsp_reset_watchdog(ctl[0]),
    .autoneg_timer_accelerate(dbg[3]), .dsp_training_shorten(dbg[2]), .link_up_forced(dbg[1]),
    .scrambler_skip(dbg[0]), .analyzer_enable(az[2]), .analyzer_pair_select(az[1]), .analyzer_pulse(az[3]),
    .analyzer_phase(phase), .analyzer_sample_window(win), .analyzer_capture_armed(az[0]));
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic rdc(input logic [5:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    pvmr_host_model_i.rd(idx, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t read not answered", $time);
      conclude();
    end else
      chk_word({8'h00, d}, {8'h00, exp});
  endtask : rdc
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rdc(6'h17, 16'h0000);
    rdc(6'h22, 16'h0000);
    rdc(6'h10, 16'h0000);
    rdc(6'h05, 16'hE3FF);
    pvmr_host_model_i.wr(6'h05, 16'h0000);
    rdc(6'h05, 16'hE3FF);
    rdc(6'h01, 16'h0010);
    @(posedge clk);
    partner <= 16'h1C20;
    rdc(6'h05, 16'h0020);
    rdc(6'h01, 16'h0000);
    pvmr_host_model_i.wr(6'h3F, 16'hFFFF);
    rdc(6'h3F, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      pvmr_host_model_i.wr(6'h17, {14'h0000, s[1:0]});
      rdc(6'h18, 16'hB600 | {7'h00, probes[s*9 +: 9]});
    end
    pvmr_host_model_i.wr(6'h17, 16'hFFFF);
    @(negedge clk);
    chk_word({20'h00000, dbg}, 24'h00000F);
    rdc(6'h17, 16'h003F);
    rdc(6'h18, 16'hF7A5);
    @(posedge clk);
    line_in[3] <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(6'h18, 16'hEFA5);
    pvmr_host_model_i.wr(6'h10, 16'hFFFF);
    @(negedge clk);
    chk_word({18'h00000, ctl}, 24'h000029);
    rdc(6'h10, 16'h003F);
    @(posedge clk);
    line_in[3] <= 1'b0;
    repeat (3) @(posedge clk);
    pvmr_host_model_i.wr(6'h10, 16'h0006);
    @(negedge clk);
    chk_word({18'h00000, ctl}, 24'h000016);
    @(posedge clk);
    line_in[0] <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_word({18'h00000, ctl}, 24'h000006);
    ph = 8'h00;
    for (int c = 0; c < 8; c++) begin
      w = {c[0], c[1], 3'b000, c[2], c[1:0], 7'h00, c[1]};
      if (c[1:0] == 2'b01)
        ph = ph + 8'h01;
      if (c[1:0] == 2'b11)
        ph = ph - 8'h01;
      pvmr_host_model_i.wr(6'h22, w);
      @(negedge clk);
      chk_word({az, phase, 4'h0, win[3:0]}, {c[2], c[0], c[1], c[0] & c[1], ph, 7'h00, c[1]});
      rdc(6'h22, w & 16'hC7FF);
    end
    conclude();
  end
endmodule : pvmr_tb_top
`default_nettype wire
